/* File: src/eep_page_prog.sv */
// page programmer for the nonvolatile array with write cache and crc-8 check
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "eep_regs.svh"

module eep_page_prog
  import eep_pkg::*;
#(
  parameter int PAGES = 16,
  parameter int PAGE_BYTES = 8,
  parameter int ADDR_W = 7,
  parameter logic [15:0] ERASE_CYCLES = `EEP_ERASE_CYCLES,
  parameter logic [15:0] PROG_CYCLES = `EEP_PROG_CYCLES
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ahb-lite
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // converter code path
  input wire logic [13:0] dacCodeIn,
  output logic [13:0] dacCode
);
  localparam int BYTES = PAGES * PAGE_BYTES;
  localparam int POWERUP_CYCLES = `EEP_POWERUP_CRC_NS / `EEP_CLK_PERIOD_NS;

  logic wrEn;
  logic rdEn;
  logic [11:0] regAddr;
  logic [7:0] array [BYTES];
  logic [7:0] cache [PAGE_BYTES];
  logic [3:0] page;
  logic [2:0] cachePtr;
  logic [ADDR_W-1:0] readAddr;
  logic [7:0] readData;
  eep_state_t state;
  logic [15:0] timer;
  logic chainProg;
  logic eraseDone;
  logic progDone;
  logic [ADDR_W-1:0] crcIdx;
  logic [7:0] crcAcc;
  logic [7:0] crcNext;
  logic crcGood;
  logic crcStartPend;
  logic powerupDone;
  logic [3:0] statusWord;
  logic [1:0] crcStatus;

  // ****************************************
  // bus front end
  // ****************************************
  eep_ahb_slave u_slave
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wrEn(wrEn),
    .rdEn(rdEn),
    .regAddr(regAddr)
  );

  eep_crc8_step u_crc
  (
    .crcIn(crcAcc),
    .dataIn(array[crcIdx]),
    .crcOut(crcNext)
  );

  logic wrPage;
  logic wrCache;
  logic wrCtrl;
  logic wrCrc;
  logic wrRead;
  assign wrPage = wrEn && regAddr == `EEP_PAGE_OFS;
  assign wrCache = wrEn && regAddr == `EEP_CACHE_OFS;
  assign wrCtrl = wrEn && regAddr == `EEP_CTRL_OFS;
  assign wrCrc = wrEn && regAddr == `EEP_CRC_CTRL_OFS;
  assign wrRead = wrEn && regAddr == `EEP_READ_ADDR_OFS;

  // ****************************************
  // page select and cache
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      page <= 4'h0;
    end
    else if (wrPage && state == EEP_IDLE)
    begin
      // upper four bits of the byte address pick the page
      page <= hwdata[6:3];
    end
  end

  // cache bytes are loaded in turn; the pointer wraps so the host must write all eight
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cachePtr <= 3'h0;
    end
    else if (wrPage && state == EEP_IDLE)
    begin
      cachePtr <= 3'h0;
    end
    else if (wrCache && state == EEP_IDLE)
    begin
      cache[cachePtr] <= hwdata[7:0];
      cachePtr <= cachePtr + 3'h1;
    end
  end

  // ****************************************
  // erase and program sequencer
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state <= EEP_CRC_RUN;
      timer <= 16'h0000;
      chainProg <= 1'b0;
      eraseDone <= 1'b0;
      progDone <= 1'b0;
      crcIdx <= '0;
      crcAcc <= `EEP_CRC_PRESET;
      crcGood <= 1'b0;
      crcStartPend <= 1'b0;
    end
    else
    begin
      case (state)
        EEP_IDLE:
        begin
          if (crcStartPend || (wrCrc && hwdata[`EEP_CRC_CMD_BIT]))
          begin
            state <= EEP_CRC_RUN;
            crcStartPend <= 1'b0;
            crcIdx <= '0;
            crcAcc <= `EEP_CRC_PRESET;
          end
          else if (wrCtrl && (hwdata[`EEP_CTRL_ERASE_PROG] || hwdata[`EEP_CTRL_ERASE]))
          begin
            state <= EEP_ERASING;
            timer <= ERASE_CYCLES;
            chainProg <= hwdata[`EEP_CTRL_ERASE_PROG];
            eraseDone <= 1'b0;
            progDone <= 1'b0;
          end
          else if (wrCtrl && hwdata[`EEP_CTRL_PROG] && eraseDone)
          begin
            state <= EEP_PROGRAMMING;
            timer <= PROG_CYCLES;
            progDone <= 1'b0;
          end
        end
        EEP_ERASING:
        begin
          if (timer == 16'h0001)
          begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
              array[{page, i[2:0]}] <= 8'h00;
            end
            eraseDone <= 1'b1;
            if (chainProg)
            begin
              state <= EEP_PROGRAMMING;
              timer <= PROG_CYCLES;
            end
            else
            begin
              state <= EEP_IDLE;
            end
          end
          else
          begin
            timer <= timer - 16'h0001;
          end
        end
        EEP_PROGRAMMING:
        begin
          if (timer == 16'h0001)
          begin
            // whole cache goes to the page in one step
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
              array[{page, i[2:0]}] <= cache[i];
            end
            progDone <= 1'b1;
            eraseDone <= 1'b0;
            state <= EEP_IDLE;
            // the last page carries the checksum byte
            crcStartPend <= (page == 4'(PAGES - 1));
          end
          else
          begin
            timer <= timer - 16'h0001;
          end
        end
        EEP_CRC_RUN:
        begin
          // checksum covers every byte ahead of the last, then compares
          if (crcIdx == ADDR_W'(BYTES - 1))
          begin
            // an unreadable array never compares equal, so it counts as a failed check
            if (crcAcc == array[crcIdx])
            begin
              crcGood <= 1'b1;
            end
            else
            begin
              crcGood <= 1'b0;
            end
            state <= EEP_IDLE;
          end
          else
          begin
            crcAcc <= crcNext;
            crcIdx <= crcIdx + ADDR_W'(1);
          end
        end
        default:
        begin
          state <= EEP_IDLE;
        end
      endcase
    end
  end

  // first check after reset is bounded by the power-up budget: 128 cycles against 85000
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      powerupDone <= 1'b0;
    end
    else if (state == EEP_IDLE && POWERUP_CYCLES > BYTES)
    begin
      powerupDone <= 1'b1;
    end
  end

  // ****************************************
  // array read port and converter gate
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      readAddr <= '0;
    end
    else if (wrRead)
    begin
      readAddr <= hwdata[ADDR_W-1:0];
    end
  end

  assign readData = array[readAddr];

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      dacCode <= 14'h0000;
    end
    else
    begin
      // a bad or zero checksum, or the first check after reset not yet finished, holds the code at zero
      dacCode <= (crcGood && powerupDone && array[BYTES-1] != 8'h00) ? dacCodeIn
        : 14'h0000;
    end
  end

  // ****************************************
  // register readback
  // ****************************************
  assign statusWord = {progDone, eraseDone, state == EEP_PROGRAMMING, state == EEP_ERASING};
  assign crcStatus = {crcGood, state == EEP_CRC_RUN || crcStartPend};

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h00000000;
    end
    else if (hsel && htrans[1] && !hwrite && hready)
    begin
      case ({haddr[11:2], 2'b00})
        `EEP_PAGE_OFS: hrdata <= {28'h0000000, page};
        `EEP_STATUS_OFS: hrdata <= {28'h0000000, statusWord};
        `EEP_CRC_STATUS_OFS: hrdata <= {30'h00000000, crcStatus};
        `EEP_READ_ADDR_OFS: hrdata <= {25'h0000000, readAddr};
        `EEP_READ_DATA_OFS: hrdata <= {24'h000000, readData};
        `EEP_DAC_OUT_OFS: hrdata <= {18'h00000, dacCode};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  logic unusedRd;
  assign unusedRd = rdEn;
endmodule

/* File: src/eep_regs.svh */
// register offsets, field positions, reset values and timing counts of the page programmer
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define EEP_PAGE_OFS 12'h000
`define EEP_CACHE_OFS 12'h004
`define EEP_CTRL_OFS 12'h008
`define EEP_STATUS_OFS 12'h00c
`define EEP_CRC_CTRL_OFS 12'h010
`define EEP_CRC_STATUS_OFS 12'h014
`define EEP_READ_ADDR_OFS 12'h018
`define EEP_READ_DATA_OFS 12'h01c
`define EEP_DAC_IN_OFS 12'h020
`define EEP_DAC_OUT_OFS 12'h024

// ****************************************
// control and status fields
// ****************************************
`define EEP_CTRL_ERASE_PROG 0
`define EEP_CTRL_ERASE 1
`define EEP_CTRL_PROG 2
`define EEP_STAT_ERASE_BUSY 0
`define EEP_STAT_PROG_BUSY 1
`define EEP_STAT_ERASE_DONE 2
`define EEP_STAT_PROG_DONE 3
`define EEP_CRC_CMD_BIT 0
`define EEP_CRC_BUSY_BIT 0
`define EEP_CRC_GOOD_BIT 1

// ****************************************
// reset values and timing
// ****************************************
`define EEP_CRC_PRESET 8'hff
`define EEP_ERASE_CYCLES 16'd1000
`define EEP_PROG_CYCLES 16'd1000
`define EEP_POWERUP_CRC_NS 340000
`define EEP_CLK_PERIOD_NS 4

`endif

/* File: src/eep_pkg.sv */
// types shared by the page programmer files
package eep_pkg;
  typedef enum logic [2:0] {
    EEP_IDLE,
    EEP_ERASING,
    EEP_PROGRAMMING,
    EEP_CRC_RUN
  } eep_state_t;
endpackage

/* File: src/eep_crc8_step.sv */
// one byte step of the array checksum
`timescale 1ns/1ps
module eep_crc8_step
(
  // current value and data byte
  input wire logic [7:0] crcIn,
  input wire logic [7:0] dataIn,
  // updated value
  output logic [7:0] crcOut
);
  logic [7:0] d;
  logic [7:0] c;
  assign d = dataIn;
  assign c = crcIn;
  assign crcOut[0] = d[7] ^ d[6] ^ d[0] ^ c[0] ^ c[6] ^ c[7];
  assign crcOut[1] = d[6] ^ d[1] ^ d[0] ^ c[0] ^ c[1] ^ c[6];
  assign crcOut[2] = d[6] ^ d[2] ^ d[1] ^ d[0] ^ c[0] ^ c[1] ^ c[2] ^ c[6];
  assign crcOut[3] = d[7] ^ d[3] ^ d[2] ^ d[1] ^ c[1] ^ c[2] ^ c[3] ^ c[7];
  assign crcOut[4] = d[4] ^ d[3] ^ d[2] ^ c[2] ^ c[3] ^ c[4];
  assign crcOut[5] = d[5] ^ d[4] ^ d[3] ^ c[3] ^ c[4] ^ c[5];
  assign crcOut[6] = d[6] ^ d[5] ^ d[4] ^ c[4] ^ c[5] ^ c[6];
  assign crcOut[7] = d[7] ^ d[6] ^ d[5] ^ c[5] ^ c[6] ^ c[7];
endmodule

/* File: src/eep_ahb_slave.sv */
// ahb-lite slave front end: latches the address phase, gives strobes in the data phase
`timescale 1ns/1ps
module eep_ahb_slave
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ahb-lite
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  // register side
  output logic wrEn,
  output logic rdEn,
  output logic [11:0] regAddr
);
  logic pendWrite;
  logic pendRead;

  // single-cycle data phase, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wrEn = pendWrite;
  assign rdEn = pendRead;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pendWrite <= 1'b0;
      pendRead <= 1'b0;
      regAddr <= 12'h000;
    end
    else if (hready)
    begin
      // only whole-word writes are decoded; other write sizes are accepted and ignored, reads of any size are decoded
      pendWrite <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
      pendRead <= hsel && htrans[1] && !hwrite;
      if (hsel && htrans[1])
      begin
        regAddr <= {haddr[11:2], 2'b00};
      end
    end
  end
endmodule

/* File: tb/eep_page_prog_monitor.sv */
// assertion checker on the page programmer ports
`timescale 1ns/1ps
module eep_page_prog_monitor
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ahb-lite
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // converter code
  input wire logic [13:0] dacCodeIn,
  input wire logic [13:0] dacCode
);
  logic rdPhase;
  logic rdQ;
  logic [11:0] addrQ;
  assign rdPhase = hsel && htrans[1] && hready && !hwrite;
  always_ff @(posedge sys_clk)
  begin
    rdQ <= rdPhase && !sys_rst;
    addrQ <= haddr;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // assertions
  // ****************************************
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  a_dac_reset: assert property ($fell(sys_rst) |-> (dacCode == 14'h0) [*8])
    else $error("converter code not held at zero after reset");
  a_dac_follow: assert property (dacCode != 14'h0 |-> dacCode == $past(dacCodeIn))
    else $error("converter code differs from its input");
  a_unmapped_zero: assert property (rdPhase && haddr == 12'h030 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!rdPhase |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_status_excl: assert property (rdQ && addrQ == 12'h00c |-> !(hrdata[0] && hrdata[1]))
    else $error("erase and program busy together");
  a_addr_width: assert property (rdQ && addrQ[11:3] == 9'h003 |-> hrdata[31:8] == 24'h0)
    else $error("array address or byte too wide");
  cover property (rdQ && addrQ == 12'h00c && hrdata[1]);
  cover property (rdQ && addrQ == 12'h014 && hrdata[0]);
  cover property (dacCode != 14'h0);
endmodule

bind eep_page_prog eep_page_prog_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dacCodeIn(dacCodeIn),
  .dacCode(dacCode));

/* File: tb/eep_host.sv */
// ahb-lite host model issuing single word transfers
`timescale 1ns/1ps
module eep_host
(
  // clock
  input wire logic sys_clk,
  // ahb-lite
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // address phase held until hready, then data phase held until hready again
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the page programmer
`timescale 1ns/1ps
module tb;
  import eep_pkg::*;
  localparam logic [15:0] CYC = 16'd8;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [13:0] dacCodeIn = 14'h0;
  logic [13:0] dacCode;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int mem [128];
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  always @(posedge sys_clk) dacCodeIn <= 14'($urandom);
  eep_host host (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  eep_page_prog #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC)) DUT (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .dacCodeIn(dacCodeIn), .dacCode(dacCode));
  // ****************************************
  // helpers and reference model
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] u;
    host.xfer(1'b1, a, d, u);
  endtask
  // polls until the masked busy bits clear; an unknown keeps polling
  task automatic waitIdle(input logic [11:0] a, input logic [31:0] m);
    int k;
    k = 0;
    rd(a);
    while ((q & m) !== 32'h0 && k < 30000)
    begin
      rd(a);
      k++;
    end
  endtask
  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] n;
    n[0] = d[7] ^ d[6] ^ d[0] ^ c[0] ^ c[6] ^ c[7];
    n[1] = d[6] ^ d[1] ^ d[0] ^ c[0] ^ c[1] ^ c[6];
    n[2] = d[6] ^ d[2] ^ d[1] ^ d[0] ^ c[0] ^ c[1] ^ c[2] ^ c[6];
    n[3] = d[7] ^ d[3] ^ d[2] ^ d[1] ^ c[1] ^ c[2] ^ c[3] ^ c[7];
    n[4] = d[4] ^ d[3] ^ d[2] ^ c[2] ^ c[3] ^ c[4];
    n[5] = d[5] ^ d[4] ^ d[3] ^ c[3] ^ c[4] ^ c[5];
    n[6] = d[6] ^ d[5] ^ d[4] ^ c[4] ^ c[5] ^ c[6];
    n[7] = d[7] ^ d[6] ^ d[5] ^ c[5] ^ c[6] ^ c[7];
    return n;
  endfunction
  function automatic logic [7:0] arrayCrc();
    logic [7:0] c;
    c = 8'hff;
    for (int i = 0; i < 127; i++)
      c = crcStep(c, mem[i][7:0]);
    return c;
  endfunction
  task automatic prog(input int pg, input bit split);
    wr(12'h000, 32'(pg << 3));
    for (int i = 0; i < 8; i++)
      wr(12'h004, 32'(mem[pg * 8 + i]));
    if (split)
    begin
      wr(12'h008, 32'h2);
      rd(12'h00c);
      chk("erase busy", q[1:0], 32'h1);
      waitIdle(12'h00c, 32'h3);
      chk("erase done", q[2], 32'h1);
      wr(12'h008, 32'h4);
    end
    else
      wr(12'h008, 32'h1);
    rd(12'h00c);
    chk("op busy", q[1:0] != 2'b00, 32'h1);
    waitIdle(12'h00c, 32'h3);
    chk("program done", q[3], 32'h1);
  endtask
  task automatic dacChk(input bit good);
    logic [13:0] prev;
    @(posedge sys_clk);
    prev = dacCodeIn;
    #1;
    chk("converter code", dacCode, good ? prev : 14'h0);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    q = $urandom(32'h672c775e);
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    waitIdle(12'h014, 32'h1);
    chk("powerup time", cyc < 85006, 32'h1);
    chk("powerup good", q[1], 32'h0);
    dacChk(1'b0);
    for (int i = 0; i < 128; i++)
      mem[i] = $urandom_range(255);
    mem[127] = arrayCrc();
    for (int p = 0; p < 16; p++)
      prog(p, p == 3);
    waitIdle(12'h014, 32'h1);
    chk("crc good", q[1], 32'h1);
    wr(12'h008, 32'h4);
    rd(12'h00c);
    chk("lone program", q[1], 32'h0);
    wr(12'h000, 32'h78);
    for (int i = 0; i < 8; i++)
      wr(12'h004, ~mem[120 + i]);
    for (int i = 0; i < 12; i++)
    begin
      int a;
      a = (i == 11) ? 127 : $urandom_range(127);
      wr(12'h018, 32'(a));
      rd(12'h01c);
      chk("array byte", q, 32'(mem[a]));
    end
    rd(12'h030);
    chk("unmapped read", q, 32'h0);
    repeat (4) dacChk(mem[127] != 0);
    mem[127] = mem[127] ^ 1;
    prog(15, 1'b0);
    waitIdle(12'h014, 32'h1);
    chk("crc bad", q[1], 32'h0);
    dacChk(1'b0);
    rd(12'h024);
    chk("code readback", q, 32'h0);
    mem[127] = mem[127] ^ 1;
    prog(15, 1'b1);
    waitIdle(12'h014, 32'h1);
    wr(12'h010, 32'h1);
    rd(12'h014);
    chk("recalc busy", q[0], 32'h1);
    waitIdle(12'h014, 32'h1);
    chk("recalc good", q[1], 32'h1);
    dacChk(mem[127] != 0);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    dacChk(1'b0);
    conclude();
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule
